// ==== verilog/ea_gen_defines.vh ====
`ifndef EA_GEN_DEFINES_VH
`define EA_GEN_DEFINES_VH

// ----------------------------------------
// Instruction formats
// ----------------------------------------
`define FMT_SHORT 1'b0
`define FMT_LONG 1'b1

// ----------------------------------------
// Address modes (4-bit encoding)
// ----------------------------------------
`define MODE_ABS_OFFSET 4'h0
`define MODE_ABS_DISP 4'h1
`define MODE_REG_IND 4'h2
`define MODE_REG_OFFSET 4'h3
`define MODE_REG_DISP 4'h4
`define MODE_REG_INDEX 4'h5
`define MODE_REG_INDEX_DISP 4'h6
`define MODE_INDEX_DISP 4'h7
`define MODE_IP_DISP 4'h8

// ----------------------------------------
// Access sizes (bytes = 1 << size up to long; triple 12 bytes, quad 16 bytes)
// ----------------------------------------
`define SIZE_BYTE 3'h0
`define SIZE_SHORT 3'h1
`define SIZE_WORD 3'h2
`define SIZE_LONG 3'h3
`define SIZE_TRIPLE 3'h4
`define SIZE_QUAD 3'h5

// ----------------------------------------
// Register operand map (7-bit)
// ----------------------------------------
`define OPND_GLOBAL_BASE 6'h00
`define OPND_LOCAL_BASE 6'h10
`define OPND_SFR_BASE 6'h20
`define OPND_LITERAL_BASE 6'h40
`define REG_PREV_FRAME 5'h10
`define NUM_SFR 3'h5

// ----------------------------------------
// Constants
// ----------------------------------------
`define IP_BIAS 32'h0000_0008
`define SHORT_OFFSET_MAX 32'h0000_0FFF
`define SCALE_MAX 3'h4
`define FRAME_PTR_RESET 32'h0000_0000

`endif

// ==== verilog/reg_file.v ====
`timescale 1ns/1ps
`include "ea_gen_defines.vh"

// Register file: globals 0-15, locals 16-31, two read ports, registered read data
module reg_file #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_b_i,
  input wire ce_i,
  // Read ports
  input wire [AW-1:0] rd_a_addr_i,
  output reg [WIDTH-1:0] rd_a_data_o,
  input wire [AW-1:0] rd_b_addr_i,
  output reg [WIDTH-1:0] rd_b_data_o,
  // Write port
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [WIDTH-1:0] wr_data_i
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clock_i) begin
    if (ce_i && wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_a_data_o <= {WIDTH{1'b0}};
      rd_b_data_o <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      rd_a_data_o <= mem[rd_a_addr_i];
      rd_b_data_o <= mem[rd_b_addr_i];
    end
  end

endmodule // reg_file

// ==== verilog/effective_address_generator.v ====
`timescale 1ns/1ps
`include "ea_gen_defines.vh"

// How it works
// - Base register value starts address sum
// - Index scaled by 1,2,4,8,16 only
// - Base plus scaled index only long format
// - Base plus constant: short offset or displacement
// - Base plus scaled index plus displacement, long
// - Scaled index plus displacement, no base
// - IP relative adds displacement plus eight
// - IP relative allowed for loads, stores, long
// - Flat 32-bit byte address space
// - Operands: 16 global, 16 local, 5 special, literals
// - Memory reached only via loads and stores
// - Local zero holds previous frame pointer
// - Unsigned byte load zero extends
// - Signed short load sign extends
// - Quad load writes four consecutive registers
// - Short format offsets below 4096
// - Short format one word, long two
module effective_address_generator #(
  parameter AW = 32
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_b_i,
  input wire ce_i,
  // Decode stage request
  input wire req_valid_i,
  input wire req_format_i,
  input wire [3:0] req_mode_i,
  input wire req_store_i,
  input wire req_signed_i,
  input wire [2:0] req_size_i,
  input wire [4:0] req_base_i,
  input wire [4:0] req_index_i,
  input wire [2:0] req_scale_i,
  input wire [11:0] req_offset_i,
  input wire [31:0] req_disp_i,
  input wire [31:0] req_ip_i,
  input wire [4:0] req_dest_i,
  // Register-to-register operand write (non-memory instructions)
  input wire opnd_wr_i,
  input wire [6:0] opnd_sel_i,
  input wire [31:0] opnd_data_i,
  // Memory unit request
  output reg mem_valid_o,
  output reg [AW-1:0] mem_addr_o,
  output reg [2:0] mem_size_o,
  output reg mem_store_o,
  output reg [31:0] mem_store_data_o,
  output reg [3:0] fetch_words_o,
  output reg req_error_o,
  // Memory unit load return
  input wire load_valid_i,
  input wire [31:0] load_data_i,
  // Status
  output reg busy_o,
  output reg [31:0] prev_frame_o
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [31:0] scale_index;
    input [31:0] value;
    input [2:0] scale;
    begin
      scale_index = value << scale;
    end
  endfunction

  function mode_legal;
    input fmt;
    input [3:0] mode;
    begin
      case (mode)
        `MODE_ABS_OFFSET, `MODE_REG_IND, `MODE_REG_OFFSET: mode_legal = (fmt == `FMT_SHORT);
        `MODE_ABS_DISP, `MODE_REG_DISP, `MODE_REG_INDEX, `MODE_REG_INDEX_DISP, `MODE_INDEX_DISP,
        `MODE_IP_DISP: mode_legal = (fmt == `FMT_LONG);
        default: mode_legal = 1'b0;
      endcase
    end
  endfunction

  function [2:0] size_regs;
    input [2:0] size;
    begin
      case (size)
        `SIZE_LONG: size_regs = 3'd2;
        `SIZE_TRIPLE: size_regs = 3'd3;
        `SIZE_QUAD: size_regs = 3'd4;
        default: size_regs = 3'd1;
      endcase
    end
  endfunction

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 4'b0001;
  localparam ST_READ = 4'b0010;
  localparam ST_LOAD = 4'b0100;
  localparam ST_ISSUE = 4'b1000;

  reg [3:0] state;
  reg [3:0] next_state;
  reg fmt_q;
  reg [3:0] mode_q;
  reg store_q;
  reg signed_q;
  reg [2:0] size_q;
  reg [2:0] scale_q;
  reg [11:0] offset_q;
  reg [31:0] disp_q;
  reg [31:0] ip_q;
  reg [4:0] dest_q;
  reg [2:0] regs_left;
  reg [2:0] regs_total;

  // ----------------------------------------
  // Register file access
  // ----------------------------------------
  wire [31:0] base_val;
  wire [31:0] index_val;
  wire [31:0] store_val;
  reg [4:0] rd_a_addr;
  reg [4:0] rd_b_addr;
  reg wr_en;
  reg [4:0] wr_addr;
  reg [31:0] wr_data;
  reg [31:0] sfr [0:4];
  reg [31:0] load_ext;
  wire opnd_is_reg;
  wire opnd_is_sfr;

  assign opnd_is_reg = (opnd_sel_i[6:5] == 2'b00);
  assign opnd_is_sfr = (opnd_sel_i[6:5] == 2'b01) && (opnd_sel_i[4:0] < {2'b00, `NUM_SFR});

  reg_file #(
    .WIDTH(32),
    .DEPTH(32),
    .AW(5)
  ) i_reg_file (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .rd_a_addr_i(rd_a_addr),
    .rd_a_data_o(base_val),
    .rd_b_addr_i(rd_b_addr),
    .rd_b_data_o(index_val),
    .wr_en_i(wr_en),
    .wr_addr_i(wr_addr),
    .wr_data_i(wr_data)
  );
  assign store_val = index_val;

  // ----------------------------------------
  // Load extension
  // ----------------------------------------
  always @* begin
    case (size_q)
      `SIZE_BYTE: load_ext = signed_q ? {{24{load_data_i[7]}}, load_data_i[7:0]}
                                      : {24'h00_0000, load_data_i[7:0]};
      `SIZE_SHORT: load_ext = signed_q ? {{16{load_data_i[15]}}, load_data_i[15:0]}
                                       : {16'h0000, load_data_i[15:0]};
      default: load_ext = load_data_i;
    endcase
  end

  // ----------------------------------------
  // Effective address sum
  // ----------------------------------------
  reg [31:0] ea;
  reg [31:0] scaled;
  always @* begin
    scaled = scale_index(index_val, scale_q);
    case (mode_q)
      `MODE_ABS_OFFSET: ea = {20'h0_0000, offset_q};
      `MODE_ABS_DISP: ea = disp_q;
      `MODE_REG_IND: ea = base_val;
      `MODE_REG_OFFSET: ea = base_val + {20'h0_0000, offset_q};
      `MODE_REG_DISP: ea = base_val + disp_q;
      `MODE_REG_INDEX: ea = base_val + scaled;
      `MODE_REG_INDEX_DISP: ea = base_val + scaled + disp_q;
      `MODE_INDEX_DISP: ea = scaled + disp_q;
      `MODE_IP_DISP: ea = ip_q + disp_q + `IP_BIAS;
      default: ea = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // Control
  // ----------------------------------------
  wire req_ok;
  assign req_ok = mode_legal(req_format_i, req_mode_i) && (req_scale_i <= `SCALE_MAX)
                  && (req_size_i <= `SIZE_QUAD);

  always @* begin
    next_state = state;
    rd_a_addr = req_base_i;
    rd_b_addr = req_index_i;
    wr_en = 1'b0;
    wr_addr = opnd_sel_i[4:0];
    wr_data = opnd_data_i;
    case (state)
      ST_IDLE: begin
        if (req_valid_i && req_ok) begin
          next_state = ST_READ;
        end else if (opnd_wr_i && opnd_is_reg) begin
          wr_en = 1'b1;
        end
      end
      ST_READ: begin
        rd_a_addr = req_base_i;
        next_state = ST_ISSUE;
      end
      ST_ISSUE: begin
        next_state = store_q ? ST_IDLE : ST_LOAD;
      end
      ST_LOAD: begin
        if (load_valid_i) begin
          wr_en = 1'b1;
          wr_addr = dest_q + {2'b00, regs_total - regs_left};
          wr_data = load_ext;
          if (regs_left == 3'd1) begin
            next_state = ST_IDLE;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      fmt_q <= `FMT_SHORT;
      mode_q <= `MODE_ABS_OFFSET;
      store_q <= 1'b0;
      signed_q <= 1'b0;
      size_q <= `SIZE_BYTE;
      scale_q <= 3'h0;
      offset_q <= 12'h000;
      disp_q <= 32'h0000_0000;
      ip_q <= 32'h0000_0000;
      dest_q <= 5'h00;
      regs_left <= 3'h0;
      regs_total <= 3'h0;
      mem_valid_o <= 1'b0;
      mem_addr_o <= {AW{1'b0}};
      mem_size_o <= `SIZE_BYTE;
      mem_store_o <= 1'b0;
      mem_store_data_o <= 32'h0000_0000;
      fetch_words_o <= 4'h0;
      req_error_o <= 1'b0;
      busy_o <= 1'b0;
      prev_frame_o <= `FRAME_PTR_RESET;
      sfr[0] <= 32'h0000_0000;
      sfr[1] <= 32'h0000_0000;
      sfr[2] <= 32'h0000_0000;
      sfr[3] <= 32'h0000_0000;
      sfr[4] <= 32'h0000_0000;
    end else if (ce_i) begin
      state <= next_state;
      mem_valid_o <= 1'b0;
      req_error_o <= 1'b0;
      busy_o <= (next_state != ST_IDLE);
      if (state == ST_IDLE && req_valid_i) begin
        req_error_o <= !req_ok;
        if (req_ok) begin
          fmt_q <= req_format_i;
          mode_q <= req_mode_i;
          store_q <= req_store_i;
          signed_q <= req_signed_i;
          size_q <= req_size_i;
          scale_q <= req_scale_i;
          offset_q <= req_offset_i;
          disp_q <= req_disp_i;
          ip_q <= req_ip_i;
          dest_q <= req_dest_i;
          regs_left <= size_regs(req_size_i);
          regs_total <= size_regs(req_size_i);
          fetch_words_o <= (req_format_i == `FMT_LONG) ? 4'h2 : 4'h1;
        end
      end
      if (state == ST_ISSUE) begin
        mem_valid_o <= 1'b1;
        mem_addr_o <= ea[AW-1:0];
        mem_size_o <= size_q;
        mem_store_o <= store_q;
        mem_store_data_o <= store_val;
      end
      if (state == ST_LOAD && load_valid_i) begin
        regs_left <= regs_left - 3'd1;
      end
      if (state == ST_IDLE && !req_valid_i && opnd_wr_i && opnd_is_sfr) begin
        sfr[opnd_sel_i[2:0]] <= opnd_data_i;
      end
      if (wr_en && wr_addr == `REG_PREV_FRAME) begin
        prev_frame_o <= wr_data;
      end
    end
  end

endmodule // effective_address_generator

// ==== verif/effective_address_generator_chk.sv ====
`timescale 1ns/1ps
`include "ea_gen_defines.vh"
module effective_address_generator_chk #(
  parameter AW = 32
) (
  // Decode side
  input wire clock_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire req_valid_i,
  input wire req_format_i,
  input wire [3:0] req_mode_i,
  input wire req_store_i,
  input wire [2:0] req_scale_i,
  input wire [11:0] req_offset_i,
  input wire [31:0] req_disp_i,
  input wire [31:0] req_ip_i,
  // Memory side
  input wire mem_valid_o,
  input wire [AW-1:0] mem_addr_o,
  input wire mem_store_o,
  input wire [3:0] fetch_words_o,
  input wire req_error_o,
  input wire busy_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  wire take = ce_i && req_valid_i && !busy_o;
  property p_issue;
    take |=> req_error_o or (busy_o ##2 mem_valid_o);
  endproperty
  a_issue: assert property (p_issue) else $error("request not answered");
  property p_pulse;
    mem_valid_o |=> !mem_valid_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("address valid too long");
  property p_short_long_only;
    take && req_format_i == `FMT_SHORT && req_mode_i >= `MODE_REG_INDEX |=> req_error_o;
  endproperty
  a_short_long_only: assert property (p_short_long_only) else $error("short mode accepted");
  property p_scale;
    take && req_scale_i > `SCALE_MAX |=> req_error_o;
  endproperty
  a_scale: assert property (p_scale) else $error("bad scale accepted");
  property p_abs_off;
    mem_valid_o && $past(req_mode_i, 3) == `MODE_ABS_OFFSET |-> mem_addr_o == {20'h0_0000, $past(req_offset_i, 3)};
  endproperty
  a_abs_off: assert property (p_abs_off) else $error("absolute offset wrong");
  property p_abs_disp;
    mem_valid_o && $past(req_mode_i, 3) == `MODE_ABS_DISP |-> mem_addr_o == $past(req_disp_i, 3);
  endproperty
  a_abs_disp: assert property (p_abs_disp) else $error("absolute address wrong");
  property p_ip;
    mem_valid_o && $past(req_mode_i, 3) == `MODE_IP_DISP |->
      mem_addr_o == $past(req_ip_i, 3) + $past(req_disp_i, 3) + `IP_BIAS;
  endproperty
  a_ip: assert property (p_ip) else $error("ip relative address wrong");
  property p_fetch;
    mem_valid_o |-> fetch_words_o == ($past(req_format_i, 3) ? 4'h2 : 4'h1);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch word count wrong");
  property p_dir;
    mem_valid_o |-> mem_store_o == $past(req_store_i, 3);
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");
endmodule // effective_address_generator_chk
bind effective_address_generator effective_address_generator_chk #(.AW(AW)) i_effective_address_generator_chk (.*);

// ==== verif/mem_model.sv ====
`timescale 1ns/1ps
`include "ea_gen_defines.vh"
module mem_model (
  input wire clock_i,
  input wire mem_valid_o,
  input wire mem_store_o,
  input wire [2:0] mem_size_o,
  output reg load_valid_i = 0,
  output reg [31:0] load_data_i = 0
);
  integer n = 0;
  integer k = 0;
  // One word a cycle after a load issue; idle bus shows junk
  always @(negedge clock_i) begin
    load_valid_i = n > 0;
    load_data_i = n > 0 ? 32'h1234_C3A9 + k : ~load_data_i;
    k = n > 0 ? k + 1 : 0;
    n = n > 0 ? n - 1 : 0;
    if (mem_valid_o && !mem_store_o)
      n = mem_size_o > `SIZE_WORD ? mem_size_o - 1 : 1;
  end
endmodule // mem_model

// ==== verif/effective_address_generator_tb.sv ====
`timescale 1ns/1ps
`include "ea_gen_defines.vh"
module effective_address_generator_tb;
  reg clock_i = 0;
  reg rst_b_i = 0;
  reg ce_i = 1;
  reg req_valid_i = 0;
  reg req_format_i = 0;
  reg req_store_i = 1;
  reg req_signed_i = 0;
  reg opnd_wr_i = 0;
  reg [3:0] req_mode_i = 0;
  reg [2:0] req_size_i = `SIZE_WORD;
  reg [2:0] req_scale_i = 0;
  reg [4:0] req_base_i = 0;
  reg [4:0] req_index_i = 0;
  reg [4:0] req_dest_i = 0;
  reg [11:0] req_offset_i = 0;
  reg [31:0] req_disp_i = 0;
  reg [31:0] req_ip_i = 0;
  reg [6:0] opnd_sel_i = 0;
  reg [31:0] opnd_data_i = 0;
  wire mem_valid_o, mem_store_o, req_error_o, busy_o, load_valid_i;
  wire [2:0] mem_size_o;
  wire [3:0] fetch_words_o;
  wire [31:0] mem_addr_o, mem_store_data_o, load_data_i, prev_frame_o;
  integer bad_count = 0;
  integer samples_checked = 0;
  integer i;
  always #25 clock_i = ~clock_i;
  effective_address_generator i_effective_address_generator (.*);
  mem_model i_mem_model (.*);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      samples_checked++;
      if (e !== g) begin
        bad_count++;
        $display("unexpected %0s: expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [6:0] s, input [31:0] d);
    begin
      @(negedge clock_i);
      opnd_sel_i = s;
      opnd_data_i = d;
      opnd_wr_i = 1;
      @(negedge clock_i);
      opnd_wr_i = 0;
    end
  endtask
  task rq(input f, input [3:0] m, input [4:0] b, x, input [2:0] sc, input [31:0] d, e, input er);
    integer j;
    begin
      @(negedge clock_i);
      req_format_i = f;
      req_mode_i = m;
      req_base_i = b;
      req_index_i = x;
      req_scale_i = sc;
      req_disp_i = d;
      req_offset_i = d[11:0];
      req_valid_i = 1;
      @(negedge clock_i);
      req_valid_i = 0;
      chk("error", er, req_error_o);
      chk("busy", !er, busy_o);
      if (!er) begin
        for (j = 0; j < 20 && mem_valid_o !== 1; j++) @(negedge clock_i);
        chk("issue", 1, mem_valid_o);
        chk("address", e, mem_addr_o);
        chk("size", req_size_i, mem_size_o);
        chk("direction", req_store_i, mem_store_o);
        chk("fetch words", f ? 32'h0000_0002 : 32'h0000_0001, fetch_words_o);
        for (j = 0; j < 20 && busy_o !== 0; j++) @(negedge clock_i);
      end
    end
  endtask
  task pk(input [4:0] r, input [31:0] e);
    begin
      rq(1, `MODE_INDEX_DISP, 0, r, 0, 0, e, 0);
      chk("store data", e, mem_store_data_o);
    end
  endtask
  task ld(input [2:0] sz, input sg, input [4:0] dst);
    begin
      req_store_i = 0;
      req_size_i = sz;
      req_signed_i = sg;
      req_dest_i = dst;
      rq(1, `MODE_ABS_DISP, 0, 0, 0, 32'h0000_0100, 32'h0000_0100, 0);
      req_store_i = 1;
      req_size_i = `SIZE_WORD;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_modes;
    begin
      wr(1, 32'h1000_0000);
      wr(2, 32'h0000_0003);
      rq(0, `MODE_ABS_OFFSET, 0, 0, 0, 32'h0000_0FFF, 32'h0000_0FFF, 0);
      rq(1, `MODE_ABS_DISP, 0, 0, 0, 32'h8000_1000, 32'h8000_1000, 0);
      rq(0, `MODE_REG_IND, 1, 0, 0, 0, 32'h1000_0000, 0);
      rq(0, `MODE_REG_OFFSET, 1, 0, 0, 32'h0000_0ABC, 32'h1000_0ABC, 0);
      rq(1, `MODE_REG_DISP, 1, 0, 0, 32'h0001_0000, 32'h1001_0000, 0);
      for (i = 0; i < 5; i++)
        rq(1, `MODE_REG_INDEX, 1, 2, i, 0, 32'h1000_0000 + (3 << i), 0);
      rq(1, `MODE_REG_INDEX_DISP, 1, 2, 3, 32'h0000_0100, 32'h1000_0118, 0);
      rq(1, `MODE_INDEX_DISP, 1, 2, 1, 32'h0000_0100, 32'h0000_0106, 0);
      req_ip_i = 32'h0000_2000;
      rq(1, `MODE_IP_DISP, 0, 0, 0, 32'h0000_0010, 32'h0000_2018, 0);
    end
  endtask
  task t_wrap;
    begin
      wr(3, 32'hFFFF_FFF0);
      rq(1, `MODE_REG_DISP, 3, 0, 0, 32'h0000_0020, 32'h0000_0010, 0);
      req_ip_i = 32'hFFFF_FFFC;
      rq(1, `MODE_IP_DISP, 0, 0, 0, 0, 32'h0000_0004, 0);
    end
  endtask
  task t_refuse;
    begin
      rq(0, `MODE_REG_INDEX, 1, 2, 0, 0, 0, 1);
      rq(0, `MODE_REG_INDEX_DISP, 1, 2, 0, 0, 0, 1);
      rq(0, `MODE_INDEX_DISP, 1, 2, 0, 0, 0, 1);
      rq(0, `MODE_IP_DISP, 0, 0, 0, 0, 0, 1);
      rq(1, `MODE_REG_INDEX, 1, 2, 5, 0, 0, 1);
    end
  endtask
  task t_loads;
    begin
      ld(`SIZE_BYTE, 0, 5);
      pk(5, 32'h0000_00A9);
      ld(`SIZE_SHORT, 1, 6);
      pk(6, 32'hFFFF_C3A9);
      ld(`SIZE_QUAD, 0, 8);
      pk(8, 32'h1234_C3A9);
      pk(11, 32'h1234_C3AC);
      ld(`SIZE_BYTE, 1, 7);
      pk(7, 32'hFFFF_FFA9);
      ld(`SIZE_LONG, 0, 12);
      pk(13, 32'h1234_C3AA);
    end
  endtask
  task t_operands;
    begin
      wr(7'h21, 32'h5A5A_0001);
      wr(7'h41, 32'h5A5A_0002);
      @(negedge clock_i);
      ce_i = 0;
      wr(1, 32'h5A5A_0003);
      ce_i = 1;
      pk(1, 32'h1000_0000);
    end
  endtask
  task t_frame;
    begin
      wr(16, 32'hCAFE_0010);
      @(negedge clock_i);
      chk("previous frame", 32'hCAFE_0010, prev_frame_o);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(negedge clock_i);
    rst_b_i = 1;
    t_modes;
    t_wrap;
    t_refuse;
    t_loads;
    t_frame;
    t_operands;
    end_of_test;
  end
  initial begin
    #100000;
    bad_count++;
    end_of_test;
  end
endmodule // effective_address_generator_tb
